// ===== shared/cbe_pkg.sv
`default_nettype none
package cbe_pkg;
    // register index of the lower port bit error status register
    localparam logic [11:0] CBE_STATUS_IDX = 12'h786;
    // byte address of that register, four times its index
    localparam logic [13:0] CBE_STATUS_ADDR = 14'h1e18;
    // interrupt mask register, a word after the status register
    localparam logic [13:0] CBE_MASK_ADDR = 14'h1e1c;
    // interrupt event register, write one to clear
    localparam logic [13:0] CBE_EVENT_ADDR = 14'h1e20;
    // status field positions
    localparam int CBE_BIT_WEAK = 0;
    localparam int CBE_BIT_SYNC = 1;
    localparam int CBE_BIT_PRE = 2;
    localparam int CBE_BIT_TAG = 3;
    localparam int CBE_BIT_ABN = 4;
    // reset values
    localparam logic [7:0] CBE_STATUS_RST = 8'h00;
    localparam logic [4:0] CBE_MASK_RST = 5'h00;
    // live bits of the status register
    localparam logic [7:0] CBE_STATUS_MASK = 8'h1f;
    // address width of the register port
    localparam int CBE_AW = 14;
endpackage : cbe_pkg
`default_nettype wire

// ===== rtl/cbe_sticky.sv
`default_nettype none
// one sticky event bit: set wins over a write-one clear
module cbe_sticky (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic set_in,
    input wire logic clr_in,
    output logic q_out
);
    logic q_reg;
    logic q_next;

    // next value: hold, clear, then set with priority
    always_comb begin
        q_next = q_reg;
        if (clr_in) begin
            q_next = 1'b0;
        end
        if (set_in) begin
            q_next = 1'b1;
        end
    end

    // register only
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            q_reg <= 1'b0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q_out = q_reg;
endmodule // cbe_sticky
`default_nettype wire

// ===== rtl/cbe_status.sv
// Added by the designer: strobed register access.
`default_nettype none
// Functional notes
// - abnormal frame sets bit 4, marks forwarded frame
// - any individual error bit sets bit 4
// - unclassified abnormality, e.g. missing data, sets bit 4
// - preamble timing lock failure sets bit 2
// - missing sync half-bit or sync pair sets bit 1
// - weak data bit sample count sets bit 0
module cbe_status (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // register port
    input wire logic [cbe_pkg::CBE_AW-1:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    // frame events from the receive front end, one-cycle pulses
    input wire logic frame_start_in,
    input wire logic frame_end_in,
    input wire logic preamble_lock_fail_in,
    input wire logic sync_miss_in,
    input wire logic weak_bit_in,
    input wire logic incoming_tag_in,
    input wire logic missing_data_in,
    // forwarded frame error marker, valid from the cycle after frame end and held to next start
    output logic forwarded_error_marker_out,
    // level interrupt
    output logic irq_out
);
    import cbe_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // status state
    logic [7:0] status_reg; // captured per frame
    logic [7:0] status_next;
    // register port state; next values ride beside their registers
    logic [4:0] mask_reg; // interrupt mask
    logic [4:0] mask_next;
    logic marker_reg; // forwarded marker
    logic marker_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic irq_reg;
    logic irq_next;
    // event bookkeeping for the interrupt
    logic [4:0] evt_set; // per bit set pulses
    logic [4:0] evt_clr; // write-one clears
    logic [4:0] evt_q; // sticky event bits
    logic indiv_err; // any classified error this cycle

    // classified errors this cycle
    assign indiv_err = preamble_lock_fail_in | sync_miss_in | weak_bit_in
        | incoming_tag_in;

    // next status: a new frame clears, events set
    always_comb begin
        // default: hold the frame's view and the marker
        status_next = status_reg;
        marker_next = marker_reg;
        // a new frame opens clean; its own events still land below
        if (frame_start_in) begin
            status_next = CBE_STATUS_RST;
            marker_next = 1'b0;
        end
        // weak data bit: too few samples for a definite level
        if (weak_bit_in) begin
            status_next[CBE_BIT_WEAK] = 1'b1;
        end
        // sync half-bit or sync pair not found
        if (sync_miss_in) begin
            status_next[CBE_BIT_SYNC] = 1'b1;
        end
        // preamble seen but timing lock lost
        if (preamble_lock_fail_in) begin
            status_next[CBE_BIT_PRE] = 1'b1;
        end
        // frame arrived already tagged upstream
        if (incoming_tag_in) begin
            status_next[CBE_BIT_TAG] = 1'b1;
        end
        // summary: any classified or unclassified abnormality
        if (indiv_err || missing_data_in) begin
            status_next[CBE_BIT_ABN] = 1'b1;
        end
        // forwarded frame carries the marker when anything went wrong
        if (frame_end_in) begin
            marker_next = status_next[CBE_BIT_ABN];
        end
        // reserved bits never hold a one
        status_next = status_next & CBE_STATUS_MASK;
    end

    // register only; status and marker share one reset so both leave reset clear together
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            // empty view, no marker
            status_reg <= CBE_STATUS_RST;
            marker_reg <= 1'b0;
        end else begin
            // take the next values
            status_reg <= status_next;
            marker_reg <= marker_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt events, one sticky bit per live status bit, bits 0 to 4
    always_comb begin
        // only a rising status bit counts as a new event
        evt_set = status_next[4:0] & ~status_reg[4:0];
        evt_clr = 5'h00;
        // write-one clears on the event address
        if (reg_wr_in && reg_addr_in == CBE_EVENT_ADDR) begin
            evt_clr = reg_wdata_in[4:0];
        end
    end

    // set wins over clear inside each bit
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_evt
            cbe_sticky u_sticky (
                .sys_clk_in(sys_clk_in),
                .sys_rst_in(sys_rst_in),
                .set_in(evt_set[gi]),
                .clr_in(evt_clr[gi]),
                .q_out(evt_q[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // register port: mask write, reads one cycle later
    always_comb begin
        mask_next = mask_reg;
        // read data is zero unless a strobe asks for it
        rdata_next = 32'h0000_0000;
        // irq follows the sticky bits through the mask
        irq_next = |(evt_q & mask_reg);
        // mask takes the low five bits of the write
        if (reg_wr_in && reg_addr_in == CBE_MASK_ADDR) begin
            mask_next = reg_wdata_in[4:0];
        end
        // status register writes fall through untouched
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                CBE_STATUS_ADDR: rdata_next = {24'h000000, status_reg};
                CBE_MASK_ADDR: rdata_next = {27'h0000000, mask_reg};
                CBE_EVENT_ADDR: rdata_next = {27'h0000000, evt_q};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    // register only
    // read data and irq are registered so the outputs never glitch
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            // all masked, nothing to read, no interrupt
            mask_reg <= CBE_MASK_RST;
            rdata_reg <= 32'h0000_0000;
            irq_reg <= 1'b0;
        end else begin
            // take the next values
            mask_reg <= mask_next;
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
        end
    end

    // every output straight from a flip-flop
    assign reg_rdata_out = rdata_reg;
    assign forwarded_error_marker_out = marker_reg;
    assign irq_out = irq_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks
    // all on the one clock; reset disables them
    // a cause is sampled one cycle before the bit it explains

    // weak data bit lands in bit 0 and the summary
    chk_weak_sets: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        weak_bit_in |=> status_reg[0] && status_reg[4])
        else $error("weak bit not recorded");

    // sync miss lands in bit 1 and the summary
    chk_sync_sets: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        sync_miss_in |=> status_reg[1] && status_reg[4])
        else $error("sync miss not recorded");

    // preamble lock failure lands in bit 2
    chk_pre_sets: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        preamble_lock_fail_in |=> status_reg[2])
        else $error("preamble fault not recorded");

    // incoming tag lands in bit 3
    chk_tag_sets: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        incoming_tag_in |=> status_reg[3])
        else $error("incoming tag not recorded");

    // no individual bit without the summary
    chk_summary_any: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (|status_reg[3:0]) |-> status_reg[4])
        else $error("summary flag missing");

    // preamble fault also raises the summary
    chk_pre_summary: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        preamble_lock_fail_in |=> status_reg[CBE_BIT_ABN])
        else $error("summary missing after preamble fault");

    // incoming tag also raises the summary
    chk_tag_summary: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        incoming_tag_in |=> status_reg[CBE_BIT_ABN])
        else $error("summary missing after incoming tag");

    // unclassified abnormality raises the summary alone
    chk_missing_data: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        missing_data_in |=> status_reg[4])
        else $error("missing data not flagged");

    // summary never rises without a cause
    chk_summary_cause: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        $rose(status_reg[CBE_BIT_ABN]) |-> $past(indiv_err) || $past(missing_data_in))
        else $error("summary rose without a cause");

    // weak bit rises only for its own event
    chk_weak_cause: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        $rose(status_reg[CBE_BIT_WEAK]) |-> $past(weak_bit_in))
        else $error("weak bit rose without a cause");

    // sync bit rises only for its own event
    chk_sync_cause: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        $rose(status_reg[CBE_BIT_SYNC]) |-> $past(sync_miss_in))
        else $error("sync bit rose without a cause");

    // preamble bit rises only for its own event
    chk_pre_cause: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        $rose(status_reg[CBE_BIT_PRE]) |-> $past(preamble_lock_fail_in))
        else $error("preamble bit rose without a cause");

    // tag bit rises only for a tagged frame
    chk_tag_cause: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        $rose(status_reg[CBE_BIT_TAG]) |-> $past(incoming_tag_in))
        else $error("tag bit rose without a cause");

    // summary at frame end marks the forwarded frame
    chk_marker_fwd: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        frame_end_in && !frame_start_in && status_reg[4] |=> forwarded_error_marker_out)
        else $error("forwarded marker not set");

    // an error in the closing cycle still marks the frame
    chk_marker_late: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        frame_end_in && !frame_start_in && (indiv_err || missing_data_in)
        |=> forwarded_error_marker_out)
        else $error("late error not forwarded");

    // a clean frame is forwarded without the marker
    chk_marker_clean: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        frame_end_in && !frame_start_in && !status_reg[CBE_BIT_ABN] && !indiv_err
        && !missing_data_in |=> !forwarded_error_marker_out)
        else $error("clean frame forwarded with marker");

    // a new frame drops the marker of the last one
    chk_marker_clear: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        frame_start_in && !frame_end_in |=> !forwarded_error_marker_out)
        else $error("marker not cleared at frame start");

    // marker moves only at a frame edge
    chk_marker_hold: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        !frame_start_in && !frame_end_in |=> $stable(forwarded_error_marker_out))
        else $error("marker moved inside a frame");

    // a new frame with no event opens with a clean view
    chk_frame_clear: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        frame_start_in && !indiv_err && !missing_data_in |=> status_reg == CBE_STATUS_RST)
        else $error("status not cleared at frame start");

    // within a frame bits only move for an event
    chk_bits_hold: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        !frame_start_in && !indiv_err && !missing_data_in |=> $stable(status_reg))
        else $error("status moved without an event");

    // reserved bits read back as zero
    chk_reserved_bits_zero: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        reg_rd_in && reg_addr_in == CBE_STATUS_ADDR |=> reg_rdata_out[31:5] == 27'h0)
        else $error("reserved bits not zero");

    // read data is the status seen at the strobe
    chk_rdata_status: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        reg_rd_in && reg_addr_in == CBE_STATUS_ADDR
        |=> reg_rdata_out[7:0] == $past(status_reg))
        else $error("read data differs from status");

    // no strobe, no data
    chk_rdata_idle: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        !reg_rd_in |=> reg_rdata_out == 32'h0000_0000)
        else $error("read data outside its cycle");

    // status writes are ignored
    chk_ro_write: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        reg_wr_in && reg_addr_in == CBE_STATUS_ADDR && !frame_start_in && !indiv_err
        && !missing_data_in |=> $stable(status_reg))
        else $error("status changed by write");
endmodule // cbe_status
`default_nettype wire

// ===== tb/cbe_nbr.sv
`default_nettype none
// neighbour device: sends one frame with chosen fault pulses
module cbe_nbr (
    input wire logic clk_in,
    output logic start_out,
    output logic end_out,
    output logic [4:0] ev_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // lines idle low between frames
    initial begin
        start_out = 1'b0;
        end_out = 1'b0;
        ev_out = 5'h00;
    end
    // start pulse, fault pulses, end pulse
    task automatic send(input logic [4:0] ev);
        @(posedge clk_in);
        start_out <= 1'b1;
        @(posedge clk_in);
        start_out <= 1'b0;
        ev_out <= ev;
        @(posedge clk_in);
        ev_out <= 5'h00;
        end_out <= 1'b1;
        @(posedge clk_in);
        end_out <= 1'b0;
    endtask
endmodule // cbe_nbr
`default_nettype wire

// ===== tb/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import cbe_pkg::*;
    logic sys_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [CBE_AW-1:0] addr = '0;
    logic [31:0] wdata = '0;
    logic [31:0] rdata;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic fs, fe, marker, irq;
    logic [4:0] ev;
    int n_mismatch = 0;
    int samples_checked = 0;
    // 20 mhz clock
    always #25 sys_clk_in = ~sys_clk_in;
    cbe_nbr nbr_u (.clk_in(sys_clk_in), .start_out(fs), .end_out(fe), .ev_out(ev));
    cbe_status dut_u (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .frame_start_in(fs), .frame_end_in(fe), .preamble_lock_fail_in(ev[2]),
        .sync_miss_in(ev[1]), .weak_bit_in(ev[0]), .incoming_tag_in(ev[3]),
        .missing_data_in(ev[4]), .forwarded_error_marker_out(marker), .irq_out(irq));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus_wr(input logic [CBE_AW-1:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk_in);
        wr <= 1'b0;
    endtask
    // data stands only in the cycle after the strobe
    task automatic bus_rd(input logic [CBE_AW-1:0] a, output logic [31:0] d);
        @(posedge sys_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_in);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [31:0] d;
        bus_rd(CBE_STATUS_ADDR, d);
        chk(d, 32'h0);
        bus_rd(14'h0000, d);
        chk(d, 32'h0);
        chk({30'h0, irq, marker}, 32'h0);
    endtask
    // each fault kind alone in a frame
    task automatic t_events;
        logic [31:0] d;
        for (int i = 0; i < 5; i++) begin
            nbr_u.send(5'h01 << i);
            bus_rd(CBE_STATUS_ADDR, d);
            chk(d, 32'h10 | ((32'h1 << i) & 32'h0f));
            chk({31'h0, marker}, 32'h1);
        end
    endtask
    // status ignores writes
    task automatic t_ro;
        logic [31:0] d;
        nbr_u.send(5'h01);
        bus_wr(CBE_STATUS_ADDR, 32'hff);
        bus_rd(CBE_STATUS_ADDR, d);
        chk(d, 32'h11);
        nbr_u.send(5'h00);
        bus_rd(CBE_STATUS_ADDR, d);
        chk(d, 32'h0);
        chk({31'h0, marker}, 32'h0);
    endtask
    // masked, unmasked, then cleared
    task automatic t_irq;
        logic [31:0] d;
        bus_wr(CBE_MASK_ADDR, 32'h0);
        bus_wr(CBE_EVENT_ADDR, 32'h1f);
        nbr_u.send(5'h02);
        repeat (2) @(posedge sys_clk_in);
        #1 chk({31'h0, irq}, 32'h0);
        bus_rd(CBE_EVENT_ADDR, d);
        chk(d, 32'h12);
        bus_wr(CBE_MASK_ADDR, 32'h1f);
        repeat (2) @(posedge sys_clk_in);
        #1 chk({31'h0, irq}, 32'h1);
        bus_rd(CBE_MASK_ADDR, d);
        chk(d, 32'h1f);
        bus_wr(CBE_EVENT_ADDR, 32'h1f);
        repeat (2) @(posedge sys_clk_in);
        #1 chk({31'h0, irq}, 32'h0);
        bus_rd(CBE_EVENT_ADDR, d);
        chk(d, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // cut a hang short
    initial begin
        #200000;
        n_mismatch++;
        print_verdict();
    end
    initial begin
        repeat (10) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        t_reset();
        t_events();
        t_ro();
        t_irq();
        print_verdict();
    end
endmodule // tb
`default_nettype wire
